// ==== inc/gps_pkg.sv ====
/*
  Package of the power-save scheduler: register map, field positions,
  reset values, timing counts and carrier types.
  Assumes a 10 MHz clock and a one-millisecond tick from the timebase.
*/
package gps_pkg;
  localparam int unsigned CLK_HZ       = 10000000;
  localparam int unsigned TICK_MS      = 1;
  localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
  // Milliseconds in one week, the longest legal interval
  localparam logic [31:0] WEEK_MS      = 32'h240c8400;
  // Orbit refresh grid, 30 minutes
  localparam int unsigned REFRESH_MIN  = 30;
  localparam logic [31:0] REFRESH_MS   = 32'(REFRESH_MIN * 60 * 1000);
  // Extra hold for a timing solution, two seconds
  localparam int unsigned TFIX_S       = 2;
  localparam logic [31:0] TFIX_MS      = 32'(TFIX_S * 1000);
  // Self-chosen limits used when a limit is written as zero
  localparam logic [31:0] AUTO_FLOOR_MS = 32'h00002710;
  localparam logic [31:0] AUTO_CEIL_MS  = 32'h0000ea60;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_UPD    = 8'h04;
  localparam logic [7:0] OFS_SRCH   = 8'h08;
  localparam logic [7:0] OFS_SHIFT  = 8'h0c;
  localparam logic [7:0] OFS_HOLD   = 8'h10;
  localparam logic [7:0] OFS_FLOOR  = 8'h14;
  localparam logic [7:0] OFS_CEIL   = 8'h18;
  localparam logic [7:0] OFS_PMREQ  = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_UPDSRC = 8'h24;

  // Control field positions
  localparam int CTL_MODE   = 0;
  localparam int CTL_NOSLP  = 1;
  localparam int CTL_TFIX   = 2;
  localparam int CTL_REFR   = 3;
  localparam int CTL_ENABLE = 4;
  // Power request fields: [31] force, [30:28] wake sources, [27:0] ms
  localparam int PMR_FORCE  = 31;
  localparam int PMR_WUART  = 28;
  localparam int PMR_WEXT   = 29;
  localparam int PMR_WSPI   = 30;
  // Idle levels of {chip select, wake pin, serial receive}
  localparam logic [2:0] PIN_IDLE = 3'b101;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [31:0] INT_RST  = 32'h000003e8;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    ST_ACQ  = 3'b000,
    ST_TRK  = 3'b001,
    ST_POT  = 3'b011,
    ST_IUPD = 3'b010,
    ST_ISRC = 3'b110,
    ST_STBY = 3'b111
  } gps_state_t;

  // Signal-side status from the navigation engine
  typedef struct packed {
    logic fix_ok;
    logic sig_weak;
    logic time_valid;
    logic time_fix;
    logic few_eph;
    logic wanted_data;
  } gps_nav_t;
endpackage

// ==== hw/gps_sched.sv ====
/*
  Power-save scheduler: sequences acquisition, tracking, power-optimized
  tracking, inactive states and software standby, with an AXI4-Lite
  register slave. Assumes nav status and wake pins are asynchronous and
  tick_in is a one-cycle pulse per millisecond on clk_in.
*/
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module gps_sched (
  input  wire logic            clk_in,
  input  wire logic            resetn_in,
  input  wire logic            ce_in,
  input  wire logic            tick_in,
  input  wire gps_pkg::gps_nav_t nav_in,
  input  wire logic            uart_rx_in,
  input  wire logic            ext_wake_in,
  input  wire logic            spi_cs_in,
  input  wire logic [31:0]     week_ms_in,
  input  wire logic [31:0]     s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [31:0]     s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  output logic [2:0]           state_out,
  output logic                 core_on_out,
  output logic                 continuous_out,
  output logic                 cfg_clear_out,
  output logic                 store_erase_out
);
  import gps_pkg::*;

  gps_state_t  st_reg;
  logic [31:0] ctrl_reg, upd_reg, srch_reg, shift_reg;
  logic [31:0] hold_reg, floor_reg, ceil_reg, pmreq_reg;
  logic [31:0] tmr_reg, sby_reg, refr_reg, tfix_reg;
  logic        stby_req_reg, host_wake_reg, in_stby_seen_reg, dl_reg;
  logic [5:0]  nav_s1, nav_s2;
  logic [2:0]  pin_s1, pin_s2, pin_d;
  logic        aw_hold, w_hold;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  gps_nav_t    nav;
  logic        tick, wr_fire, cyc, pin_edge, grid_hit, srch_hit;
  logic [31:0] floor_eff, ceil_eff, grid_pos;

  // Wrap the grid position: mod of week time minus shift
  function automatic logic [31:0] grid_mod(input logic [31:0] t,
                                           input logic [31:0] p);
    grid_mod = (p == 32'h0) ? 32'h1 : t % p;
  endfunction

  // Two-flop synchronisers for navigation status and wake pins
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      nav_s1 <= '0;
      nav_s2 <= '0;
      // Idle levels, so release of reset shows no false wake edge
      pin_s1 <= PIN_IDLE;
      pin_s2 <= PIN_IDLE;
      pin_d  <= PIN_IDLE;
    end else if (ce_in) begin
      nav_s1 <= nav_in;
      nav_s2 <= nav_s1;
      pin_s1 <= {spi_cs_in, ext_wake_in, uart_rx_in};
      pin_s2 <= pin_s1;
      pin_d  <= pin_s2;
    end
  end

  assign nav  = gps_nav_t'(nav_s2);
  assign tick = tick_in & ce_in;
  assign cyc  = (ctrl_reg[CTL_MODE] == 1'b0);
  // Any edge on an enabled wake source
  assign pin_edge = |((pin_s2 ^ pin_d) & pmreq_reg[30:28]);
  assign floor_eff = (floor_reg == 32'h0) ? AUTO_FLOOR_MS : floor_reg;
  assign ceil_eff  = (ceil_reg == 32'h0) ? AUTO_CEIL_MS : ceil_reg;
  // Before valid time the grid runs on local time, unshifted
  assign grid_pos = nav.time_valid ? (week_ms_in - shift_reg)
                                   : week_ms_in;
  assign grid_hit = (upd_reg != 32'h0) &&
                    (grid_mod(grid_pos, upd_reg) == 32'h0);
  assign srch_hit = (srch_reg != 32'h0) &&
                    (grid_mod(grid_pos, srch_reg) == 32'h0);

  // Write channels latched independently, response after both
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold && !s_axi_bvalid;
  assign wr_fire       = aw_hold && w_hold && !s_axi_bvalid;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      aw_hold      <= 1'b0;
      w_hold       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (ce_in) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr > OFS_PMREQ) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration store; standby entry wipes it back to reset values
  always_ff @(posedge clk_in) begin
    if (!resetn_in || (ce_in && stby_req_reg)) begin
      ctrl_reg  <= CTRL_RST;
      upd_reg   <= INT_RST;
      srch_reg  <= INT_RST;
      shift_reg <= 32'h0;
      hold_reg  <= INT_RST;
      floor_reg <= 32'h0;
      ceil_reg  <= 32'h0;
    end else if (ce_in && wr_fire) begin
      unique case (aw_addr)
        OFS_CTRL:  ctrl_reg  <= w_data;
        // Values past one week leave the old interval in force
        OFS_UPD:   if (w_data <= WEEK_MS) upd_reg <= w_data;
        OFS_SRCH:  if (w_data <= WEEK_MS) srch_reg <= w_data;
        OFS_SHIFT: shift_reg <= w_data;
        OFS_HOLD:  hold_reg  <= w_data;
        OFS_FLOOR: floor_reg <= w_data;
        OFS_CEIL:  ceil_reg  <= w_data;
        default: ;
      endcase
    end
  end

  // Power request latch: only a forced request arms standby
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pmreq_reg    <= 32'h0;
      stby_req_reg <= 1'b0;
    end else if (ce_in) begin
      stby_req_reg <= 1'b0;
      if (wr_fire && aw_addr == OFS_PMREQ && w_data[PMR_FORCE]) begin
        pmreq_reg    <= w_data;
        stby_req_reg <= 1'b1;
      end
    end
  end

  // Host wake pulse in inactive-update when update interval is zero
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      host_wake_reg <= 1'b0;
    end else if (ce_in) begin
      host_wake_reg <= |(pin_s2 ^ pin_d);
    end
  end

  // Read channel; status shows the live state
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ce_in) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        unique case (s_axi_araddr[7:0])
          OFS_CTRL:   s_axi_rdata <= ctrl_reg;
          OFS_UPD:    s_axi_rdata <= upd_reg;
          OFS_SRCH:   s_axi_rdata <= srch_reg;
          OFS_SHIFT:  s_axi_rdata <= shift_reg;
          OFS_HOLD:   s_axi_rdata <= hold_reg;
          OFS_FLOOR:  s_axi_rdata <= floor_reg;
          OFS_CEIL:   s_axi_rdata <= ceil_reg;
          OFS_PMREQ:  s_axi_rdata <= pmreq_reg;
          OFS_STATUS: s_axi_rdata <= {26'h0, dl_reg, core_on_out,
                                      in_stby_seen_reg, st_reg};
          OFS_UPDSRC: s_axi_rdata <= tmr_reg;
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Orbit data download window: 30-minute grid or few valid ephemerides
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      refr_reg <= 32'h0;
      dl_reg   <= 1'b0;
    end else if (tick) begin
      refr_reg <= (refr_reg >= REFRESH_MS - 32'h1) ? 32'h0
                                                    : refr_reg + 32'h1;
      if (nav.few_eph ||
          (ctrl_reg[CTL_REFR] && refr_reg == 32'h0)) begin
        dl_reg <= 1'b1;
      end else if (!nav.wanted_data) begin
        dl_reg <= 1'b0;
      end
    end
  end

  // Main sequencer; timers advance one step per millisecond tick
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      st_reg   <= ST_ACQ;
      tmr_reg  <= 32'h0;
      sby_reg  <= 32'h0;
      tfix_reg <= 32'h0;
    end else if (ce_in && stby_req_reg) begin
      st_reg  <= ST_STBY;
      sby_reg <= {4'h0, w_data[27:0]};
    end else if (ce_in && st_reg == ST_STBY && pin_edge) begin
      st_reg  <= ST_ACQ;
      tmr_reg <= 32'h0;
    end else if (tick) begin
      tmr_reg <= tmr_reg + 32'h1;
      unique case (st_reg)
        ST_ACQ: begin
          tfix_reg <= nav.time_fix ? tfix_reg + 32'h1 : 32'h0;
          if (nav.fix_ok && (!ctrl_reg[CTL_TFIX] ||
              tfix_reg >= TFIX_MS)) begin
            // Good signal needs no floor wait
            if (!nav.sig_weak || tmr_reg >= floor_eff ||
                ctrl_reg[CTL_NOSLP]) begin
              st_reg  <= ST_TRK;
              tmr_reg <= 32'h0;
            end
          end else if (!ctrl_reg[CTL_NOSLP] && !dl_reg &&
                       (tmr_reg >= ceil_eff ||
                        (tmr_reg >= floor_eff && nav.sig_weak))) begin
            st_reg  <= ST_ISRC;
            tmr_reg <= 32'h0;
          end
        end
        ST_TRK: begin
          if (!nav.fix_ok) begin
            st_reg  <= ST_ACQ;
            tmr_reg <= 32'h0;
          end else if (tmr_reg >= hold_reg && !dl_reg) begin
            st_reg  <= cyc ? ST_POT : ST_IUPD;
            tmr_reg <= 32'h0;
          end
        end
        ST_POT: begin
          if (nav.sig_weak || !nav.fix_ok || !cyc) begin
            st_reg  <= ST_TRK;
            tmr_reg <= 32'h0;
          end
        end
        ST_IUPD: begin
          if (grid_hit || dl_reg ||
              (upd_reg == 32'h0 && host_wake_reg)) begin
            st_reg  <= ST_ACQ;
            tmr_reg <= 32'h0;
          end
        end
        ST_ISRC: begin
          if (srch_hit || dl_reg) begin
            st_reg  <= ST_ACQ;
            tmr_reg <= 32'h0;
          end
        end
        ST_STBY: begin
          if (sby_reg != 32'h0) begin
            sby_reg <= sby_reg - 32'h1;
            if (sby_reg == 32'h1) begin
              st_reg  <= ST_ACQ;
              tmr_reg <= 32'h0;
            end
          end
        end
        default: st_reg <= ST_ACQ;
      endcase
    end
  end

  // Reset pin seen during standby erases the battery-backed store
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      in_stby_seen_reg <= 1'b0;
      store_erase_out  <= in_stby_seen_reg;
    end else if (ce_in) begin
      in_stby_seen_reg <= (st_reg == ST_STBY);
      store_erase_out  <= 1'b0;
    end
  end

  // Outputs from flip-flops; core supply off only in standby
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_out      <= ST_ACQ;
      core_on_out    <= 1'b1;
      continuous_out <= 1'b0;
      cfg_clear_out  <= 1'b0;
    end else if (ce_in) begin
      state_out      <= st_reg;
      core_on_out    <= (st_reg != ST_STBY);
      continuous_out <= dl_reg;
      cfg_clear_out  <= stby_req_reg;
    end
  end

  a_week_reject: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ce_in && wr_fire && aw_addr == OFS_UPD && w_data > WEEK_MS &&
     !stby_req_reg) |=> $stable(upd_reg))
    else $error("Oversized update interval was stored");
  a_force_needed: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (st_reg != ST_STBY && !stby_req_reg) |=> st_reg != ST_STBY)
    else $error("Standby entered without forced request");
  a_stby_core: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ce_in && st_reg == ST_STBY) |=> !core_on_out)
    else $error("Core supply on during standby");
  a_nosleep_stay: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ctrl_reg[CTL_NOSLP] && st_reg == ST_ACQ && !stby_req_reg)
      |=> st_reg != ST_ISRC)
    else $error("Inactive-search entered with never sleep");
  a_cyc_no_iupd: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (st_reg == ST_TRK && cyc && !stby_req_reg) |=> st_reg != ST_IUPD)
    else $error("Cyclic mode went to inactive-update");
  a_tick_only: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!tick_in && !stby_req_reg && !(st_reg == ST_STBY && pin_edge))
      |=> $stable(st_reg))
    else $error("State moved between ticks");
  a_trk_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (st_reg == ST_TRK && tick && nav.fix_ok && tmr_reg < hold_reg &&
     !stby_req_reg) |=> st_reg == ST_TRK)
    else $error("Tracking left before hold time");
  a_cfg_wipe: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ce_in && stby_req_reg) |=> (ctrl_reg == CTRL_RST && cfg_clear_out))
    else $error("Configuration survived standby entry");
endmodule // gps_sched

// ==== tb/gps_host_model.sv ====
/*
  Host-side pin model: makes wake edges on the UART receive line, the
  external wake pin and the SPI chip select.
  Assumes one-cycle request pulses from the bench, on clk_in.
*/
`timescale 1ns/1ps
module gps_host_model (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic [2:0] wake_req_in,
  output logic            uart_rx_out,
  output logic            ext_wake_out,
  output logic            spi_cs_out
);
  // Lines rest at their idle levels; each request flips one pin, so
  // every request is exactly one wake edge, never a glitch pair
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      uart_rx_out  <= 1'b1; // Serial line idles high
      ext_wake_out <= 1'b0;
      spi_cs_out   <= 1'b1; // Chip not selected
    end else begin
      uart_rx_out  <= uart_rx_out ^ wake_req_in[0];
      ext_wake_out <= ext_wake_out ^ wake_req_in[1];
      spi_cs_out   <= spi_cs_out ^ wake_req_in[2];
    end
  end
endmodule // gps_host_model

// ==== tb/gps_sched_tb.sv ====
/*
  Self-checking bench of the power-save scheduler.
  Assumes one tick per clock while ticks run, so cycles count as ms.
*/
`timescale 1ns/1ps
module gps_sched_tb;
  import gps_pkg::*;
  logic        clk_in     = 1'b0;
  logic        resetn_in  = 1'b0;
  logic        ce_in      = 1'b1;
  logic        tick_in    = 1'b0;
  logic        tick_run   = 1'b0;
  gps_nav_t    nav_in     = '0;
  logic [2:0]  wake_req   = 3'h0;
  logic [31:0] week_ms_in = 32'h0;
  logic [31:0] awaddr     = 32'h0;
  logic [31:0] wdata      = 32'h0;
  logic [31:0] araddr     = 32'h0;
  logic        awvalid    = 1'b0;
  logic        wvalid     = 1'b0;
  logic        bready     = 1'b0;
  logic        arvalid    = 1'b0;
  logic        rready     = 1'b0;
  logic        clr_seen   = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        uart_rx, ext_wake, spi_cs, core_on, cont, cfg_clr, erase;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] rdata, rdat;
  logic [2:0]  state;
  int          fails      = 0;
  int          checked    = 0;
  int          cyc        = 0;
  int          n;

  // 10 MHz clock
  always #50 clk_in = ~clk_in;
  // Tick every cycle while running; week time follows the tick
  always @(posedge clk_in) begin
    tick_in <= tick_run;
    if (tick_in) week_ms_in <= week_ms_in + 32'h1;
  end
  // The clear pulse lasts one cycle, so keep a sticky copy
  always @(posedge clk_in) if (cfg_clr === 1'b1) clr_seen <= 1'b1;
  // Hang guard, well above the expected run length
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails = fails + 1;
      finish_test();
    end
  end

  gps_host_model i_host (.clk_in(clk_in), .resetn_in(resetn_in),
    .wake_req_in(wake_req), .uart_rx_out(uart_rx),
    .ext_wake_out(ext_wake), .spi_cs_out(spi_cs));

  gps_sched i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .tick_in(tick_in), .nav_in(nav_in), .uart_rx_in(uart_rx),
    .ext_wake_in(ext_wake), .spi_cs_in(spi_cs), .week_ms_in(week_ms_in),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .state_out(state), .core_on_out(core_on),
    .continuous_out(cont), .cfg_clear_out(cfg_clr),
    .store_erase_out(erase));

  task automatic finish_test();
    $display("TB: checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // Counts are bench values, so plain ints suffice here
  task automatic chkrng(input int g, input int lo, input int hi);
    checked++;
    if (g < lo || g > hi) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h..%h", $time, g, lo, hi);
    end
  endtask

  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_in);
    awaddr  <= {24'h0, a};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk_in);
      k++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && k < 100);
    rsp = bresp;
    bready <= 1'b0;
    if (k >= 100) fails++;
  endtask

  task automatic rd(input logic [7:0] a);
    int k;
    k = 0;
    @(posedge clk_in);
    araddr  <= {24'h0, a};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk_in);
      k++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && k < 100);
    rdat = rdata;
    rsp  = rresp;
    rready <= 1'b0;
    if (k >= 100) fails++;
  endtask

  // Wait for a state; n holds the cycles taken
  task automatic wst(input logic [2:0] s, input int lim);
    n = 0;
    while (state !== s && n < lim) begin
      @(posedge clk_in);
      n++;
    end
    chkrng(n, 0, lim - 1);
  endtask

  task automatic wcont(input logic v);
    n = 0;
    while (cont !== v && n < 20) begin
      @(posedge clk_in);
      n++;
    end
    chkrng(n, 0, 19);
  endtask

  task automatic wake(input int b);
    @(posedge clk_in);
    wake_req <= 3'h1 << b;
    @(posedge clk_in);
    wake_req <= 3'h0;
  endtask

  // Reset with ticks stopped, configure, then let time run
  task automatic go(input logic [31:0] c, fl, ce, ho, up, se, sh,
                    input gps_nav_t nv);
    tick_run <= 1'b0;
    @(posedge clk_in);
    resetn_in <= 1'b0;
    nav_in    <= nv;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    wr(OFS_FLOOR, fl);
    wr(OFS_CEIL, ce);
    wr(OFS_HOLD, ho);
    wr(OFS_UPD, up);
    wr(OFS_SRCH, se);
    wr(OFS_SHIFT, sh);
    wr(OFS_CTRL, c | 32'h10); // Mode goes in last, with enable
    tick_run <= 1'b1;
  endtask

  task automatic s_regs();
    rd(OFS_CTRL);
    chk32(rdat, CTRL_RST);
    rd(OFS_UPD);
    chk32(rdat, INT_RST);
    rd(8'h40);
    chk32({30'h0, rsp}, {30'h0, RESP_SLVERR});
    chk32(rdat, 32'h0);
    wr(8'h40, 32'h1);
    chk32({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(OFS_UPD, WEEK_MS);
    wr(OFS_UPD, WEEK_MS + 32'h1);
    rd(OFS_UPD);
    chk32(rdat, WEEK_MS);
    wr(OFS_SRCH, 32'hffffffff);
    rd(OFS_SRCH);
    chk32(rdat, INT_RST);
  endtask

  task automatic s_acq();
    go(0, 20, 200, 10, 1000, 1000, 0, gps_nav_t'(6'h10));
    repeat (10) @(posedge clk_in);
    tick_run <= 1'b0;
    repeat (50) @(posedge clk_in);
    chk32({29'h0, state}, {29'h0, ST_ACQ});
    tick_run <= 1'b1;
    wst(ST_ISRC, 60);
    chkrng(n + 10, 19, 28);
    go(0, 5, 40, 10, 1000, 1000, 0, gps_nav_t'(6'h00));
    wst(ST_ISRC, 80);
    chkrng(n, 39, 46);
    go(2, 5, 40, 10, 1000, 1000, 0, gps_nav_t'(6'h00));
    repeat (150) @(posedge clk_in);
    chk32({29'h0, state}, {29'h0, ST_ACQ});
  endtask

  task automatic s_track();
    // Short ceilings keep the run brief; real hosts keep them long
    go(0, 20, 200, 10, 5, 1000, 0, gps_nav_t'(6'h20));
    wst(ST_TRK, 40);
    wst(ST_POT, 40);
    chkrng(n, 10, 14);
    repeat (60) @(posedge clk_in);
    chk32({29'h0, state}, {29'h0, ST_POT});
    go(1, 20, 200, 10, 50, 1000, 7, gps_nav_t'(6'h28));
    wst(ST_TRK, 40);
    wst(ST_IUPD, 40);
    chkrng(n, 10, 14);
    wst(ST_ACQ, 120);
    chkrng(int'((week_ms_in - 32'h7) % 32'd50), 0, 4);
    go(1, 5, 20, 10, 1000, 30, 0, gps_nav_t'(6'h00));
    wst(ST_ISRC, 50);
    wst(ST_ACQ, 80);
    chkrng(int'(week_ms_in % 32'd30), 0, 4);
    go(1, 5, 200, 5, 0, 1000, 0, gps_nav_t'(6'h20));
    wst(ST_IUPD, 60);
    repeat (200) @(posedge clk_in);
    chk32({29'h0, state}, {29'h0, ST_IUPD});
    wake(0);
    wst(ST_ACQ, 10);
  endtask

  task automatic s_misc();
    go(4, 1, 10000, 10, 1000, 1000, 0, gps_nav_t'(6'h20));
    repeat (100) @(posedge clk_in);
    chk32({29'h0, state}, {29'h0, ST_ACQ});
    nav_in.time_fix <= 1'b1;
    wst(ST_TRK, 2100);
    chkrng(n, 2000, 2100);
    go(0, 20, 200, 10, 1000, 1000, 0, gps_nav_t'(6'h23));
    wcont(1'b1);
    nav_in <= gps_nav_t'(6'h20);
    wcont(1'b0);
    go(8, 20, 200, 10, 1000, 1000, 0, gps_nav_t'(6'h21));
    wcont(1'b1);
  endtask

  task automatic s_stby();
    go(8, 20, 200, 10, 1000, 1000, 0, gps_nav_t'(6'h20));
    wr(OFS_PMREQ, 32'h20000000);
    repeat (20) @(posedge clk_in);
    chk32({31'h0, core_on}, 32'h1);
    // Each wake source in turn: uart, wake pin, chip select
    for (int b = 0; b < 3; b++) begin
      clr_seen <= 1'b0;
      wr(OFS_PMREQ, 32'h80000000 | (32'h1 << (28 + b)));
      wst(ST_STBY, 10);
      chk32({31'h0, core_on}, 32'h0);
      chk32({31'h0, clr_seen}, 32'h1);
      wake(b);
      wst(ST_ACQ, 20);
    end
    rd(OFS_CTRL);
    chk32(rdat, CTRL_RST);
    wr(OFS_PMREQ, 32'h80000019);
    wst(ST_STBY, 10);
    wst(ST_ACQ, 40);
    chkrng(n, 23, 30);
    wr(OFS_PMREQ, 32'ha0000000);
    wst(ST_STBY, 10);
    @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk32({31'h0, erase}, 32'h1);
    resetn_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    chk32({29'h0, state}, {29'h0, ST_ACQ});
    chk32({31'h0, core_on}, 32'h1);
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    s_regs();
    s_acq();
    s_track();
    s_misc();
    s_stby();
    finish_test();
  end
endmodule // gps_sched_tb
